// [verilog/iqc_pkg.sv]
// Shared constants, types and decoders for the I/Q path correction register bank
package iqc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] IQC_OFF_I_COEF0 = 8'h20;
  localparam logic [7:0] IQC_OFF_I_COEF1 = 8'h21;
  localparam logic [7:0] IQC_OFF_I_COEF2 = 8'h22;
  localparam logic [7:0] IQC_OFF_I_COEF3 = 8'h23;
  localparam logic [7:0] IQC_OFF_Q_COEF0 = 8'h24;
  localparam logic [7:0] IQC_OFF_Q_COEF1 = 8'h25;
  localparam logic [7:0] IQC_OFF_Q_COEF2 = 8'h26;
  localparam logic [7:0] IQC_OFF_Q_COEF3 = 8'h27;
  localparam logic [7:0] IQC_OFF_I_PHASE_LOW = 8'h28;
  localparam logic [7:0] IQC_OFF_I_PHASE_HIGH = 8'h29;
  localparam logic [7:0] IQC_OFF_Q_PHASE_LOW = 8'h2A;
  localparam logic [7:0] IQC_OFF_Q_PHASE_HIGH = 8'h2B;
  localparam logic [7:0] IQC_OFF_I_OFFSET_LOW = 8'h2C;
  localparam logic [7:0] IQC_OFF_I_OFFSET_HIGH = 8'h2D;
  localparam logic [7:0] IQC_OFF_Q_OFFSET_LOW = 8'h2E;
  localparam logic [7:0] IQC_OFF_Q_OFFSET_HIGH = 8'h2F;
  localparam logic [3:0] IQC_BLOCK_PAGE = 4'h2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] IQC_RST_I_COEF0 = 8'h00;
  localparam logic [7:0] IQC_RST_I_COEF1 = 8'hC0;
  localparam logic [7:0] IQC_RST_I_COEF2 = 8'hEF;
  localparam logic [7:0] IQC_RST_I_COEF3 = 8'h7F;
  localparam logic [7:0] IQC_RST_Q_COEF0 = 8'h69;
  localparam logic [7:0] IQC_RST_Q_COEF1 = 8'hE6;
  localparam logic [7:0] IQC_RST_Q_COEF2 = 8'h0D;
  localparam logic [7:0] IQC_RST_Q_COEF3 = 8'h00;
  localparam logic [7:0] IQC_RST_ZERO = 8'h00;

  // Only bits 1:0 of the phase high bytes exist
  localparam logic [7:0] IQC_MASK_PHASE_HIGH = 8'h03;
  localparam logic [7:0] IQC_MASK_FULL = 8'hFF;

  // ----------------------------------------------------------------
  // Storage geometry and widths
  // ----------------------------------------------------------------
  localparam int IQC_BANK_BYTES = 16;
  localparam int IQC_STORE_DEPTH = 32;
  localparam int IQC_CHANNELS = 4;
  localparam int IQC_TAPS_W = 29;
  localparam int IQC_PHASE_W = 10;
  localparam int IQC_SMP_W = 16;

  typedef logic [IQC_TAPS_W-1:0] iqc_taps_t;

  function automatic logic [7:0] iqc_reset_of(input logic [3:0] idx);
    logic [7:0] v;
    v = IQC_RST_ZERO;
    case (idx)
      IQC_OFF_I_COEF0[3:0]: v = IQC_RST_I_COEF0;
      IQC_OFF_I_COEF1[3:0]: v = IQC_RST_I_COEF1;
      IQC_OFF_I_COEF2[3:0]: v = IQC_RST_I_COEF2;
      IQC_OFF_I_COEF3[3:0]: v = IQC_RST_I_COEF3;
      IQC_OFF_Q_COEF0[3:0]: v = IQC_RST_Q_COEF0;
      IQC_OFF_Q_COEF1[3:0]: v = IQC_RST_Q_COEF1;
      IQC_OFF_Q_COEF2[3:0]: v = IQC_RST_Q_COEF2;
      IQC_OFF_Q_COEF3[3:0]: v = IQC_RST_Q_COEF3;
      default: v = IQC_RST_ZERO;
    endcase
    return v;
  endfunction

  function automatic logic [7:0] iqc_wmask(input logic [3:0] idx);
    logic [7:0] m;
    m = IQC_MASK_FULL;
    if (idx == IQC_OFF_I_PHASE_HIGH[3:0] || idx == IQC_OFF_Q_PHASE_HIGH[3:0]) begin
      m = IQC_MASK_PHASE_HIGH;
    end
    return m;
  endfunction

  // Packs {fifth, fourth, third, second, first} tap from the four coefficient bytes
  function automatic iqc_taps_t iqc_taps(input logic [7:0] b0, input logic [7:0] b1,
                                         input logic [7:0] b2, input logic [7:0] b3);
    return {b3[6:0], b2[7:5], b2[3:0], b1[7:5], b1[4:0], b0[6:3], b0[2:0]};
  endfunction

endpackage

// [verilog/iqc_store_if.sv]
// Carrier between the register front end, the byte store and the correction stage
`timescale 1ns/100ps
`default_nettype none
interface iqc_store_if;
  import iqc_pkg::*;
  logic wr;
  logic [4:0] waddr;
  logic [7:0] wdata;
  logic rd;
  logic rhit;
  logic [4:0] raddr;
  logic [7:0] rdata;
  logic [7:0] img [IQC_STORE_DEPTH];

  modport ctl (output wr, waddr, wdata, rd, rhit, raddr, input rdata, img);
  modport store (input wr, waddr, wdata, rd, rhit, raddr, output rdata, img);
  modport user (input img);
endinterface
`default_nettype wire

// [verilog/iqc_byte_store.sv]
// Two banks of sixteen configuration bytes with a registered read port
`timescale 1ns/100ps
`default_nettype none
module iqc_byte_store
  import iqc_pkg::*;
#(
  parameter int DEPTH = IQC_STORE_DEPTH
) (
  input wire logic i_clk,
  input wire logic i_rst,
  iqc_store_if.store st
);

  logic [7:0] mem_r [DEPTH];
  logic [7:0] mem_nxt [DEPTH];
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // A read in the same cycle as a write to that byte returns the old value
  always_comb begin
    mem_nxt = mem_r;
    if (st.wr) begin
      mem_nxt[st.waddr] = st.wdata;
    end
    rdata_nxt = rdata_r;
    if (st.rd) begin
      rdata_nxt = st.rhit ? mem_r[st.raddr] : 8'h00;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_r[i] <= iqc_reset_of(4'(i));
      end
      rdata_r <= 8'h00;
    end else begin
      mem_r <= mem_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign st.img = mem_r;
  assign st.rdata = rdata_r;

endmodule
`default_nettype wire

// [verilog/iqc_corr_apply.sv]
// Per-channel DC offset addition and gated phase word outputs
`timescale 1ns/100ps
`default_nettype none
module iqc_corr_apply
  import iqc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  iqc_store_if.user st,
  input wire logic i_bypass,
  input wire logic [IQC_CHANNELS-1:0][IQC_SMP_W-1:0] i_smp,
  input wire logic i_smp_valid,
  output logic [IQC_CHANNELS-1:0][IQC_SMP_W-1:0] o_smp,
  output logic o_smp_valid,
  output logic [IQC_CHANNELS-1:0][IQC_PHASE_W-1:0] o_phase
);

  logic [IQC_CHANNELS-1:0][IQC_SMP_W-1:0] bias_w;
  logic [IQC_CHANNELS-1:0][IQC_PHASE_W-1:0] phase_w;
  logic [IQC_CHANNELS-1:0][IQC_SMP_W-1:0] smp_r, smp_nxt;
  logic [IQC_CHANNELS-1:0][IQC_PHASE_W-1:0] phase_r, phase_nxt;
  logic valid_r, valid_nxt;

  // ----------------------------------------------------------------
  // Field pick-up: even channels are I paths, odd ones Q paths
  // ----------------------------------------------------------------
  for (genvar c = 0; c < IQC_CHANNELS; c++) begin : g_ch
    localparam int BASE = (c / 2) * IQC_BANK_BYTES;
    localparam int PL = (c % 2 == 1) ? int'(IQC_OFF_Q_PHASE_LOW[3:0]) : int'(IQC_OFF_I_PHASE_LOW[3:0]);
    localparam int PH = (c % 2 == 1) ? int'(IQC_OFF_Q_PHASE_HIGH[3:0]) : int'(IQC_OFF_I_PHASE_HIGH[3:0]);
    localparam int OL = (c % 2 == 1) ? int'(IQC_OFF_Q_OFFSET_LOW[3:0]) : int'(IQC_OFF_I_OFFSET_LOW[3:0]);
    localparam int OH = (c % 2 == 1) ? int'(IQC_OFF_Q_OFFSET_HIGH[3:0]) : int'(IQC_OFF_I_OFFSET_HIGH[3:0]);
    assign phase_w[c] = {st.img[BASE + PH][1:0], st.img[BASE + PL]}; // R9 R10
    assign bias_w[c] = {st.img[BASE + OH], st.img[BASE + OL]}; // R11 R12
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Twos complement sum wraps at 16 bits; no saturation, which keeps the path one adder deep
  always_comb begin
    smp_nxt = smp_r;
    valid_nxt = i_smp_valid;
    for (int c = 0; c < IQC_CHANNELS; c++) begin
      if (i_smp_valid) begin
        smp_nxt[c] = IQC_SMP_W'(i_smp[c] + bias_w[c]); // R11 R12 R13
      end
      phase_nxt[c] = i_bypass ? '0 : phase_w[c]; // R14
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      smp_r <= '0;
      phase_r <= '0;
      valid_r <= 1'b0;
    end else begin
      smp_r <= smp_nxt;
      phase_r <= phase_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign o_smp = smp_r;
  assign o_phase = phase_r;
  assign o_smp_valid = valid_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_i_bias_add: assert property (@(posedge i_clk) disable iff (i_rst) // R11
    i_smp_valid |=> o_smp[0] == IQC_SMP_W'($past(i_smp[0]) + $past(bias_w[0])) && o_smp_valid)
    else $error("I sample did not receive its offset");
  chk_q_bias_add: assert property (@(posedge i_clk) disable iff (i_rst) // R12
    i_smp_valid |=> o_smp[1] == IQC_SMP_W'($past(i_smp[1]) + $past(bias_w[1])))
    else $error("Q sample did not receive its offset");
  chk_bias_signed: assert property (@(posedge i_clk) disable iff (i_rst) // R13
    i_smp_valid && i_smp[2] == '0 && bias_w[2][IQC_SMP_W-1] |=> $signed(o_smp[2]) < 0)
    else $error("Negative offset not applied as negative");
  chk_bypass_phase: assert property (@(posedge i_clk) disable iff (i_rst) // R14
    i_bypass [*2] |=> o_phase == '0 ##1 (o_phase == '0 || !$past(i_bypass)))
    else $error("Phase word leaked while bypassed");
  chk_i_phase_word: assert property (@(posedge i_clk) disable iff (i_rst) // R9
    !i_bypass |=> o_phase[0] == $past(phase_w[0]) && o_phase[2] == $past(phase_w[2]))
    else $error("I phase word not presented");
  chk_q_phase_word: assert property (@(posedge i_clk) disable iff (i_rst) // R10
    !i_bypass |=> o_phase[1] == $past(phase_w[1]) && o_phase[3] == $past(phase_w[3]))
    else $error("Q phase word not presented");

endmodule
`default_nettype wire

// [verilog/iqc_regs_top.sv]
// Byte-wide register bank for I/Q path correction of a four channel transmit converter
`timescale 1ns/100ps
`default_nettype none

// What this block does
// R1: First tap, 3 bits, first byte 2:0
// R2: Second tap, 4 bits, first byte 6:3
// R3: Third tap, 5 bits, second byte 4:0
// R4: Fourth tap split across bytes two, three
// R5: Fifth tap split across bytes three, four
// R6: Software writes zero to spare bits
// R7: I writes go to channel one or three
// R8: Q writes go to channel two or four
// R9: Ten-bit I phase word from 0x28/0x29
// R10: Ten-bit Q phase word from 0x2A/0x2B
// R11: Sixteen-bit I offset added to samples
// R12: Sixteen-bit Q offset added to samples
// R13: Phase and offset words are signed
// R14: Bypass set means phase words ignored
module iqc_regs_top
  import iqc_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_path_sel,
  input wire logic i_bypass,
  input wire logic [IQC_CHANNELS-1:0][IQC_SMP_W-1:0] i_smp,
  input wire logic i_smp_valid,
  output logic [7:0] o_rdata,
  output logic o_rvalid,
  output logic [IQC_CHANNELS-1:0][IQC_TAPS_W-1:0] o_taps,
  output logic [IQC_CHANNELS-1:0][IQC_PHASE_W-1:0] o_phase,
  output logic [IQC_CHANNELS-1:0][IQC_SMP_W-1:0] o_smp,
  output logic o_smp_valid
);

  iqc_store_if st ();

  logic hit;
  logic rvalid_r, rvalid_nxt;

  // ----------------------------------------------------------------
  // Address decode and bank steering
  // ----------------------------------------------------------------
  // The path-select bit picks the bank: bank 0 feeds channels one/two, bank 1 three/four
  assign hit = (i_addr[7:4] == IQC_BLOCK_PAGE);
  assign st.wr = i_wr && hit;
  assign st.waddr = {i_path_sel, i_addr[3:0]}; // R7 R8
  // Spare bits of phase high bytes are dropped; other spare bits keep what software wrote
  assign st.wdata = i_wdata & iqc_wmask(i_addr[3:0]);
  assign st.rd = i_rd;
  assign st.rhit = hit;
  assign st.raddr = {i_path_sel, i_addr[3:0]};

  always_comb begin
    rvalid_nxt = i_rd;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= rvalid_nxt;
    end
  end

  assign o_rvalid = rvalid_r;
  assign o_rdata = st.rdata;

  // ----------------------------------------------------------------
  // Storage and correction stage
  // ----------------------------------------------------------------
  iqc_byte_store #(
    .DEPTH(IQC_STORE_DEPTH)
  ) u_store (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .st(st.store)
  );

  iqc_corr_apply u_apply (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .st(st.user),
    .i_bypass(i_bypass),
    .i_smp(i_smp),
    .i_smp_valid(i_smp_valid),
    .o_smp(o_smp),
    .o_smp_valid(o_smp_valid),
    .o_phase(o_phase)
  );

  // ----------------------------------------------------------------
  // Tap fields, read straight off the stored bytes
  // ----------------------------------------------------------------
  for (genvar c = 0; c < IQC_CHANNELS; c++) begin : g_taps
    localparam int BASE = (c / 2) * IQC_BANK_BYTES + ((c % 2 == 1) ? int'(IQC_OFF_Q_COEF0[3:0]) : 0);
    assign o_taps[c] = iqc_taps(st.img[BASE], st.img[BASE + 1], st.img[BASE + 2], st.img[BASE + 3]); // R1 R2 R3 R4 R5
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_first_byte_taps: assert property (@(posedge i_clk) disable iff (i_rst) // R1 R2
    i_wr && i_addr == IQC_OFF_I_COEF0 && !i_path_sel |=> o_taps[0][6:0] == $past(i_wdata[6:0]))
    else $error("First coefficient byte did not land in taps one and two");
  chk_third_tap: assert property (@(posedge i_clk) disable iff (i_rst) // R3
    i_wr && i_addr == IQC_OFF_I_COEF1 && !i_path_sel |=> o_taps[0][11:7] == $past(i_wdata[4:0]))
    else $error("Third tap not taken from second byte");
  chk_fourth_tap: assert property (@(posedge i_clk) disable iff (i_rst) // R4
    i_wr && i_addr == IQC_OFF_Q_COEF2 && !i_path_sel
    |=> o_taps[1][18:15] == $past(i_wdata[3:0]) && o_taps[1][14:12] == $past(o_taps[1][14:12]))
    else $error("Fourth tap high bits misplaced");
  chk_fifth_tap: assert property (@(posedge i_clk) disable iff (i_rst) // R5
    i_wr && i_addr == IQC_OFF_I_COEF3 && i_path_sel |=> o_taps[2][28:22] == $past(i_wdata[6:0]))
    else $error("Fifth tap high bits misplaced");
  chk_i_bank_route: assert property (@(posedge i_clk) disable iff (i_rst) // R7
    i_wr && i_addr == IQC_OFF_I_COEF0 && i_path_sel
    |=> $stable(o_taps[0]) && o_taps[2][6:0] == $past(i_wdata[6:0]))
    else $error("I write reached the wrong channel");
  chk_q_bank_route: assert property (@(posedge i_clk) disable iff (i_rst) // R8
    i_wr && i_addr == IQC_OFF_Q_COEF0 && !i_path_sel
    |=> $stable(o_taps[3]) && $stable(o_taps[0]) && o_taps[1][6:0] == $past(i_wdata[6:0]))
    else $error("Q write reached the wrong channel");
  chk_read_answer: assert property (@(posedge i_clk) disable iff (i_rst)
    i_rd && !hit |=> o_rvalid && o_rdata == 8'h00)
    else $error("Unmapped read did not return zero");

endmodule
`default_nettype wire

// [bench/iq_path_correction_regs_test.sv]
// Self-checking testbench for the I/Q path correction register bank
`timescale 1ns/100ps
`default_nettype none
module iq_path_correction_regs_test;
  import iqc_pkg::*;
  logic i_clk, i_rst, i_wr, i_rd, i_path_sel, i_bypass, i_smp_valid, o_rvalid, o_smp_valid;
  logic [7:0] i_addr, i_wdata, o_rdata, wd;
  logic [IQC_CHANNELS-1:0][IQC_SMP_W-1:0] i_smp, o_smp, e, se;
  logic [IQC_CHANNELS-1:0][IQC_TAPS_W-1:0] o_taps;
  logic [IQC_CHANNELS-1:0][IQC_PHASE_W-1:0] o_phase;
  logic [7:0] m [2][16];
  logic [7:0] rq [$];
  logic [IQC_CHANNELS-1:0][IQC_SMP_W-1:0] sq [$];
  int miscompares, n_compared, seed;
  localparam logic [7:0] RV [8] = '{8'h00, 8'hC0, 8'hEF, 8'h7F, 8'h69, 8'hE6, 8'h0D, 8'h00};

  iqc_regs_top DUT (.i_clk(i_clk), .i_rst(i_rst), .i_wr(i_wr), .i_rd(i_rd), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_path_sel(i_path_sel), .i_bypass(i_bypass), .i_smp(i_smp),
    .i_smp_valid(i_smp_valid), .o_rdata(o_rdata), .o_rvalid(o_rvalid), .o_taps(o_taps),
    .o_phase(o_phase), .o_smp(o_smp), .o_smp_valid(o_smp_valid));

  initial begin
    i_clk = 1'b0;
    forever #4 i_clk = ~i_clk;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
    n_compared++;
    if (got !== ex) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", nm, ex, got);
    end
  endtask

  // One register access; the read expectation is noted before the write lands
  task automatic acc(input logic w, input logic r, input logic s, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    i_wr = w;
    i_rd = r;
    i_path_sel = s;
    i_addr = a;
    i_wdata = d;
    i_smp_valid = 1'b0;
    if (r) rq.push_back(a[7:4] == 4'h2 ? m[s][a[3:0]] : 8'h00);
    if (w && a[7:4] == 4'h2) m[s][a[3:0]] = (a[3:0] == 4'h9 || a[3:0] == 4'hB) ? (d & 8'h03) : d;
  endtask

  task automatic idle(input int n);
    repeat (n) begin
      @(negedge i_clk);
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_smp_valid = 1'b0;
    end
  endtask

  task automatic smp(input logic [63:0] v);
    @(negedge i_clk);
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_smp = v;
    i_smp_valid = 1'b1;
    for (int c = 0; c < 4; c++) begin
      e[c] = v[16*c +: 16] + {m[c/2][(c%2) ? 15 : 13], m[c/2][(c%2) ? 14 : 12]};
    end
    sq.push_back(e);
  endtask

  task automatic read_all();
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 16; i++) acc(1'b0, 1'b1, s[0], 8'h20 + 8'(i), 8'h00);
    end
    idle(2);
  endtask

  // I channels take bytes 0..3, Q channels bytes 4..7 of their bank
  task automatic check_outs();
    int b;
    int k;
    for (int c = 0; c < 4; c++) begin
      b = c / 2;
      k = (c % 2) * 4;
      chk("taps", {m[b][k+3][6:0], m[b][k+2][7:5], m[b][k+2][3:0], m[b][k+1][7:5], m[b][k+1][4:0], m[b][k][6:3], m[b][k][2:0]}, o_taps[c]);
      k = (c % 2) * 2 + 8;
      chk("phase", i_bypass ? 10'h000 : {m[b][k+1][1:0], m[b][k]}, o_phase[c]);
    end
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Result monitor
  // ------------------------------------------------------------
  always @(posedge i_clk) begin
    #1;
    if (o_rvalid === 1'b1) begin
      if (rq.size() == 0) chk("spare read", 32'h0, 32'h1);
      else chk("read data", rq.pop_front(), o_rdata);
    end
    if (o_smp_valid === 1'b1) begin
      if (sq.size() == 0) chk("spare sample", 32'h0, 32'h1);
      else begin
        se = sq.pop_front();
        for (int c = 0; c < 4; c++) chk("sample", se[c], o_smp[c]);
      end
    end
  end

  initial begin
    #200000;
    miscompares++;
    $display("MISMATCH watchdog expected done seen hang");
    final_report();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {i_wr, i_rd, i_path_sel, i_smp_valid, i_addr, i_wdata, i_smp} = '0;
    i_bypass = 1'b1;
    i_rst = 1'b1;
    seed = 54;
    for (int i = 0; i < 16; i++) begin
      m[0][i] = (i < 8) ? RV[i] : 8'h00;
      m[1][i] = m[0][i];
    end
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    i_rst = 1'b0;
    check_outs();
    read_all();
    // Random contents in both banks, coefficient spare bits kept clear by software
    for (int s = 0; s < 2; s++) begin
      for (int i = 0; i < 16; i++) begin
        // Built aside so the write still standing from the last call keeps its data
        wd = 8'($random(seed));
        if (i == 0 || i == 3 || i == 4 || i == 7) wd[7] = 1'b0;
        if (i == 2 || i == 6) wd[4] = 1'b0;
        acc(1'b1, 1'b0, s[0], 8'h20 + 8'(i), wd);
      end
    end
    idle(3);
    check_outs();
    read_all();
    // Unmapped places must neither store nor alias into the bank
    acc(1'b1, 1'b0, 1'b0, 8'h30, 8'hFF);
    acc(1'b1, 1'b0, 1'b1, 8'h1F, 8'hFF);
    acc(1'b0, 1'b1, 1'b0, 8'h30, 8'h00);
    acc(1'b0, 1'b1, 1'b0, 8'h20, 8'h00);
    acc(1'b0, 1'b1, 1'b1, 8'h2F, 8'h00);
    // Same-cycle read and write of one byte returns the old value
    acc(1'b1, 1'b1, 1'b0, 8'h2C, 8'hA5);
    acc(1'b0, 1'b1, 1'b0, 8'h2C, 8'h00);
    idle(3);
    // Phase words at both signed extremes with bypass released
    acc(1'b1, 1'b0, 1'b0, 8'h28, 8'h00);
    acc(1'b1, 1'b0, 1'b0, 8'h29, 8'hFE);
    acc(1'b1, 1'b0, 1'b1, 8'h2A, 8'hFF);
    acc(1'b1, 1'b0, 1'b1, 8'h2B, 8'h01);
    idle(1);
    i_bypass = 1'b0;
    idle(3);
    check_outs();
    acc(1'b0, 1'b1, 1'b0, 8'h29, 8'h00);
    i_bypass = 1'b1;
    idle(3);
    check_outs();
    // Offset of minus one on channel one, negative offset on channel three, then back-to-back samples
    acc(1'b1, 1'b0, 1'b0, 8'h2C, 8'hFF);
    acc(1'b1, 1'b0, 1'b0, 8'h2D, 8'hFF);
    acc(1'b1, 1'b0, 1'b1, 8'h2D, 8'h80);
    idle(2);
    smp({16'h8000, 16'h0000, 16'hFFFF, 16'h0005});
    for (int n = 0; n < 20; n++) smp({$random(seed), $random(seed)});
    idle(1);
    smp({$random(seed), $random(seed)});
    idle(3);
    chk("queues empty", 32'h0, rq.size() + sq.size());
    // Second reset in mid-run restores the reset bytes
    i_rst = 1'b1;
    for (int i = 0; i < 16; i++) begin
      m[0][i] = (i < 8) ? RV[i] : 8'h00;
      m[1][i] = m[0][i];
    end
    idle(2);
    i_rst = 1'b0;
    check_outs();
    read_all();
    final_report();
  end
endmodule
`default_nettype wire
